//--- gtm_pkg.sv
// Package for the gated 16-bit timer: offsets, fields, reset values
package gtm_pkg;
    localparam logic [2:0] ADDR_COUNT_LOW   = 3'h0;
    localparam logic [2:0] ADDR_COUNT_HIGH  = 3'h1;
    localparam logic [2:0] ADDR_TIMER_CTRL  = 3'h2;
    localparam logic [2:0] ADDR_GATE_CTRL   = 3'h3;
    localparam logic [2:0] ADDR_INT_CTRL    = 3'h4;
    // timer_control fields
    localparam int TC_ON        = 0;
    localparam int TC_SYNC      = 2;
    localparam int TC_PS_LO     = 4;
    localparam int TC_CS_LO     = 6;
    // gate_control fields
    localparam int GC_SS_LO     = 0;
    localparam int GC_VAL       = 2;
    localparam int GC_GO        = 3;
    localparam int GC_SPM       = 4;
    localparam int GC_TM        = 5;
    localparam int GC_POL       = 6;
    localparam int GC_GE        = 7;
    // int_control fields
    localparam int IC_OVF_FLAG  = 0;
    localparam int IC_OVF_IE    = 1;
    localparam int IC_GATE_FLAG = 2;
    localparam int IC_GATE_IE   = 3;
    localparam int IC_PERIPHERAL_INT_ENABLE      = 4;
    localparam int IC_GIE       = 5;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
    localparam logic [7:0] GATE_CTRL_RESET  = 8'h00;
    localparam logic [7:0] INT_CTRL_RESET   = 8'h00;
    localparam logic [7:0] TC_WMASK         = 8'hf5;
    localparam logic [7:0] GC_WMASK         = 8'hfb;
    localparam logic [7:0] IC_WMASK         = 8'h3f;
    localparam logic [1:0] CS_INSTR   = 2'h0;
    localparam logic [1:0] CS_SYSTEM  = 2'h1;
    localparam logic [1:0] CS_PIN     = 2'h2;
    localparam logic [1:0] CS_LFOSC   = 2'h3;
    localparam logic [1:0] GS_PIN     = 2'h0;
    localparam logic [1:0] GS_T8OVF   = 2'h1;
    localparam logic [1:0] GS_COMP    = 2'h2;
    localparam logic [7:0] T8_MAX     = 8'hff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage : gtm_pkg

//--- gtm_timer.sv
// Gated 16-bit timer/counter with gate front end and register port
//
// Notes on behaviour
// R1: Gate source select: 00 pin, 01 8-bit overflow, 10 comparator, 11 reserved.
// R2: 8-bit timer wrap from maximum to zero makes a gate pulse.
// R3: Toggle mode routes gate through a flip-flop toggling on rising edges.
// R4: Toggle flip-flop held cleared while toggle mode is off.
// R5: Single-pulse: enable first, then go; counting starts at next gate edge.
// R6: Go bit cleared by hardware at trailing edge of captured pulse.
// R7: After a single pulse, no gate event counts until go is set again.
// R8: Software should clear go when disabling single-pulse mode.
// R9: Toggle and single-pulse together capture one full gate cycle.
// R10: Gate level readable as status, valid even with gating disabled.
// R11: Falling gate-value edge sets gate flag; interrupt only if enabled.
// R12: Gate flag keeps working while gate control is disabled.
// R13: Count rollover from maximum to zero sets overflow flag.
// R14: Overflow interrupt needs timer on, overflow, peripheral and global enables.
// R15: Software clears overflow flag; zero count and flag before enabling.
// R16: In sleep only async external counting runs; overflow wakes device.
// R17: Clock select: 11 low-freq osc, 10 pin rising, 01 system, 00 instruction.
// R18: Prescaler divides by 1, 2, 4 or 8.
// R19: Sync bit 1 counts external clock unsynchronised, 0 synchronised.
// R20: Timer-on cleared stops counting and clears gate flip-flop.
// R21: Gate enable ignored when off; on, 1 gates counting, 0 counts freely.
// R22: Polarity 1 active-high gate, 0 active-low gate.
// R23: Writing either count byte clears prescaler and loads the counter.
// R24: Count increments on prescaled clock edge only while gate active.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module gtm_timer
    import gtm_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    input  wire logic       external_gate_pin,
    input  wire logic       external_clock_pin,
    input  wire logic       low_freq_internal_osc,
    input  wire logic       comparator1_output,
    input  wire logic [7:0] timer8_count,
    input  wire logic       sleep_mode,
    output logic            overflow_irq,
    output logic            gate_event_irq,
    output logic            wake_up
);
    typedef enum logic [2:0] {
        GTM_SP_IDLE  = 3'b001,
        GTM_SP_ARMED = 3'b010,
        GTM_SP_OPEN  = 3'b100
    } gtm_sp_e;

    logic        rst_meta;
    logic        rst_sync_n;
    logic [7:0]  timer_control;
    logic [7:0]  gate_control;
    logic [7:0]  int_control;
    logic [15:0] count;
    logic [2:0]  prescale;
    logic [1:0]  instr_div;
    logic [2:0]  pin_gate_s;
    logic [2:0]  pin_clk_s;
    logic [2:0]  lfo_s;
    logic [2:0]  comp_s;
    logic [7:0]  t8_prev;
    logic        toggle_ff;
    logic        gate_val;
    logic        gate_val_prev;
    logic        src_prev;
    logic        clk_lvl_prev;
    gtm_sp_e     sp_state;
    logic        pin_gate_lvl;
    logic        pin_clk_lvl;
    logic        lfo_lvl;
    logic        comp_lvl;
    logic        t8_wrap;
    logic        gate_src;
    logic        src_rise;
    logic        next_gate_val;
    logic        clk_lvl;
    logic        src_tick;
    logic        pre_tick;
    logic        gate_open;
    logic        count_en;
    logic        wr_low;
    logic        wr_high;
    logic        ovf_set;
    logic        gate_fall;
    logic        sleep_run;
    logic [2:0]  prescale_last;

    // Settled level once the second and third stage agree
    function automatic logic settled(input logic [2:0] s, input logic old);
        settled = (s[1] == s[2]) ? s[2] : old;
    endfunction : settled

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // Pin synchronisers; only stages 2 and 3 are looked at by logic
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_gate_s <= 3'h0;
            pin_clk_s  <= 3'h0;
            lfo_s      <= 3'h0;
            comp_s     <= 3'h0;
        end
        else
        begin
            pin_gate_s <= {pin_gate_s[1:0], external_gate_pin};
            pin_clk_s  <= {pin_clk_s[1:0], external_clock_pin};
            lfo_s      <= {lfo_s[1:0], low_freq_internal_osc};
            comp_s     <= {comp_s[1:0], comparator1_output};
        end
    end

    logic pin_gate_q;
    logic pin_clk_q;
    logic lfo_q;
    logic comp_q;
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_gate_q <= 1'b0;
            pin_clk_q  <= 1'b0;
            lfo_q      <= 1'b0;
            comp_q     <= 1'b0;
        end
        else
        begin
            pin_gate_q <= pin_gate_lvl;
            pin_clk_q  <= pin_clk_lvl;
            lfo_q      <= lfo_lvl;
            comp_q     <= comp_lvl;
        end
    end

    assign pin_gate_lvl = settled(pin_gate_s, pin_gate_q);
    assign pin_clk_lvl  = settled(pin_clk_s, pin_clk_q);
    assign lfo_lvl      = settled(lfo_s, lfo_q);
    assign comp_lvl     = settled(comp_s, comp_q);

    // 8-bit timer is on our clock, so no synchroniser
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            t8_prev <= 8'h00;
        else
            t8_prev <= timer8_count;
    end
    assign t8_wrap = (t8_prev == T8_MAX) && (timer8_count == 8'h00); // R2

    always_comb
    begin
        case (gate_control[GC_SS_LO +: 2]) // R1
            GS_PIN:   gate_src = pin_gate_lvl;
            GS_T8OVF: gate_src = t8_wrap;
            GS_COMP:  gate_src = comp_lvl;
            default:  gate_src = 1'b0;
        endcase
    end

    // Polarity applied before toggle so the toggle sees incrementing edges
    logic pol_src;
    assign pol_src  = gate_control[GC_POL] ? gate_src : ~gate_src; // R22
    assign src_rise = pol_src && !src_prev;

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            src_prev <= 1'b0;
        else
            src_prev <= pol_src;
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            toggle_ff <= 1'b0;
        else if (!gate_control[GC_TM] || !timer_control[TC_ON]) // R4 R20
            toggle_ff <= 1'b0;
        else if (src_rise)
            toggle_ff <= ~toggle_ff; // R3
    end

    assign next_gate_val = gate_control[GC_TM] ? toggle_ff : pol_src; // R3 R9

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            gate_val      <= 1'b0;
            gate_val_prev <= 1'b0;
        end
        else
        begin
            gate_val      <= next_gate_val; // R10
            gate_val_prev <= gate_val;
        end
    end
    assign gate_fall = gate_val_prev && !gate_val; // R11 R12

    // Single-pulse sequencer
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sp_state <= GTM_SP_IDLE;
        else if (!gate_control[GC_SPM] || !gate_control[GC_GO])
            sp_state <= GTM_SP_IDLE;
        else
        begin
            case (sp_state)
                GTM_SP_IDLE:  sp_state <= gate_val ? GTM_SP_IDLE : GTM_SP_ARMED;
                GTM_SP_ARMED: sp_state <= gate_val ? GTM_SP_OPEN : GTM_SP_ARMED; // R5
                GTM_SP_OPEN:  sp_state <= gate_val ? GTM_SP_OPEN : GTM_SP_IDLE;
                default:      sp_state <= GTM_SP_IDLE;
            endcase
        end
    end

    logic sp_done;
    assign sp_done = (sp_state == GTM_SP_OPEN) && !gate_val; // R6

    // Outside the open window nothing counts in single-pulse mode while gate enable is set
    assign gate_open = gate_control[GC_SPM] ? ((sp_state == GTM_SP_OPEN) && gate_val) // R7
                                            : gate_val;

    // Clock source and prescale
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            instr_div <= 2'h0;
        else
            instr_div <= instr_div + 2'h1;
    end

    // Async mode uses the second stage directly: one cycle earlier, may skip
    always_comb
    begin
        case (timer_control[TC_CS_LO +: 2]) // R17
            CS_PIN:
                clk_lvl = timer_control[TC_SYNC] ? pin_clk_s[1] : pin_clk_lvl; // R19
            CS_LFOSC: clk_lvl = lfo_lvl;
            default:  clk_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            clk_lvl_prev <= 1'b0;
        else
            clk_lvl_prev <= clk_lvl;
    end

    always_comb
    begin
        case (timer_control[TC_CS_LO +: 2])
            CS_INSTR:  src_tick = (instr_div == INSTR_DIV_LAST);
            CS_SYSTEM: src_tick = 1'b1;
            default:   src_tick = clk_lvl && !clk_lvl_prev;
        endcase
    end

    // Sleep stops the system clocks; only async external counting survives
    assign sleep_run = !sleep_mode ||
        ((timer_control[TC_CS_LO +: 2] == CS_PIN) && timer_control[TC_SYNC]); // R16

    assign prescale_last = (3'h1 << timer_control[TC_PS_LO +: 2]) - 3'h1; // R18
    assign pre_tick = src_tick && (prescale == prescale_last);
    assign wr_low   = wr_en && (addr == ADDR_COUNT_LOW);
    assign wr_high  = wr_en && (addr == ADDR_COUNT_HIGH);

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            prescale <= 3'h0;
        else if (wr_low || wr_high || !timer_control[TC_ON]) // R23
            prescale <= 3'h0;
        else if (src_tick && sleep_run)
            prescale <= pre_tick ? 3'h0 : prescale + 3'h1; // R18
    end

    assign count_en = timer_control[TC_ON] && sleep_run && pre_tick &&
                      (!gate_control[GC_GE] || gate_open); // R20 R21 R24
    assign ovf_set  = count_en && (count == COUNT_MAX); // R13

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            count <= 16'h0000;
        else if (wr_low)
            count <= {count[15:8], wdata}; // R23
        else if (wr_high)
            count <= {wdata, count[7:0]}; // R23
        else if (count_en)
            count <= count + 16'h0001; // R24
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            timer_control <= TIMER_CTRL_RESET;
        else if (wr_en && addr == ADDR_TIMER_CTRL)
            timer_control <= wdata & TC_WMASK;
    end

    // Hardware clear of go wins only over a stale value, never over a write
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            gate_control <= GATE_CTRL_RESET;
        else if (wr_en && addr == ADDR_GATE_CTRL)
            gate_control <= wdata & GC_WMASK;
        else if (sp_done)
            gate_control[GC_GO] <= 1'b0; // R6
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            int_control <= INT_CTRL_RESET;
        else
        begin
            if (wr_en && addr == ADDR_INT_CTRL)
                int_control <= wdata & IC_WMASK; // R15
            if (ovf_set)
                int_control[IC_OVF_FLAG] <= 1'b1; // R13
            if (gate_fall)
                int_control[IC_GATE_FLAG] <= 1'b1; // R11 R12
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            overflow_irq   <= 1'b0;
            gate_event_irq <= 1'b0;
            wake_up        <= 1'b0;
        end
        else
        begin
            overflow_irq   <= int_control[IC_OVF_FLAG] && int_control[IC_OVF_IE] &&
                              timer_control[TC_ON] && int_control[IC_PERIPHERAL_INT_ENABLE] &&
                              int_control[IC_GIE]; // R14
            gate_event_irq <= int_control[IC_GATE_FLAG] && int_control[IC_GATE_IE] &&
                              int_control[IC_PERIPHERAL_INT_ENABLE] && int_control[IC_GIE]; // R11
            wake_up        <= int_control[IC_OVF_FLAG] && int_control[IC_OVF_IE] &&
                              timer_control[TC_ON] && int_control[IC_PERIPHERAL_INT_ENABLE]; // R16
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rdata <= 8'h00;
        else if (rd_en)
        begin
            case (addr)
                ADDR_COUNT_LOW:  rdata <= count[7:0];
                ADDR_COUNT_HIGH: rdata <= count[15:8];
                ADDR_TIMER_CTRL: rdata <= timer_control;
                ADDR_GATE_CTRL:  rdata <= {gate_control[7:3], gate_val, gate_control[1:0]};
                ADDR_INT_CTRL:   rdata <= int_control;
                default:         rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end
endmodule : gtm_timer

//--- gtm_far.sv
// Far-side model: external clock pin, slow oscillator, 8-bit timer
`timescale 1ns/1ps
module gtm_far
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       t8_run,
    input  wire logic       clk_run,
    output logic [7:0]      t8_count,
    output logic            clk_pin,
    output logic            lf_osc
);
    logic [2:0] div;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t8_count <= 8'h00;
            div      <= 3'h0;
        end
        else
        begin
            div <= div + 3'h1;
            if (t8_run)
                t8_count <= t8_count + 8'h01;
        end
    end

    // Pin clock stands low outside bursts
    assign clk_pin = clk_run & div[1];
    assign lf_osc  = div[2];
endmodule : gtm_far

//--- gtm_timer_asserts.sv
// Port checker for the gated timer
`timescale 1ns/1ps
module gtm_chk
    import gtm_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       external_gate_pin,
    input wire logic       external_clock_pin,
    input wire logic       low_freq_internal_osc,
    input wire logic       comparator1_output,
    input wire logic [7:0] timer8_count,
    input wire logic       sleep_mode,
    input wire logic       overflow_irq,
    input wire logic       gate_event_irq,
    input wire logic       wake_up
);
    logic [7:0] sh_tc;
    logic [7:0] sh_gc;
    logic [7:0] sh_ic;

    // Shadow of software-owned bits; hardware flags left out
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_tc <= TIMER_CTRL_RESET;
            sh_gc <= GATE_CTRL_RESET;
            sh_ic <= INT_CTRL_RESET;
        end
        else if (wr_en)
        begin
            if (addr == ADDR_TIMER_CTRL)
                sh_tc <= wdata & TC_WMASK;
            if (addr == ADDR_GATE_CTRL)
                sh_gc <= wdata & GC_WMASK;
            if (addr == ADDR_INT_CTRL)
                sh_ic <= wdata & IC_WMASK;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ovf_irq_en_a: assert property (
        overflow_irq |-> $past(sh_tc[TC_ON] & sh_ic[IC_OVF_IE] & sh_ic[IC_PERIPHERAL_INT_ENABLE] & sh_ic[IC_GIE]))
        else $error("overflow irq without all enables");
    gate_irq_en_a: assert property (
        gate_event_irq |-> $past(sh_ic[IC_GATE_IE] & sh_ic[IC_PERIPHERAL_INT_ENABLE] & sh_ic[IC_GIE]))
        else $error("gate irq without enables");
    wake_en_a: assert property (
        wake_up |-> $past(sh_tc[TC_ON] & sh_ic[IC_OVF_IE] & sh_ic[IC_PERIPHERAL_INT_ENABLE]))
        else $error("wake without enables");
    ctrl_read_a: assert property (
        $past(rd_en) && $past(addr) == ADDR_TIMER_CTRL |-> rdata == $past(sh_tc))
        else $error("timer control read mismatch");
    gate_read_a: assert property (
        $past(rd_en) && $past(addr) == ADDR_GATE_CTRL |-> (rdata & 8'hf3) == ($past(sh_gc) & 8'hf3))
        else $error("gate control read mismatch");
    int_read_a: assert property (
        $past(rd_en) && $past(addr) == ADDR_INT_CTRL |-> (rdata & 8'h3a) == ($past(sh_ic) & 8'h3a))
        else $error("interrupt enable read mismatch");
    count_load_a: assert property (
        (wr_en && addr == ADDR_COUNT_LOW && !sh_tc[TC_ON]) ##1 !wr_en ##1
        (rd_en && addr == ADDR_COUNT_LOW) |=> rdata == $past(wdata, 3))
        else $error("count write not loaded");
    count_hold_a: assert property (
        (rd_en && addr == ADDR_COUNT_LOW && !sh_tc[TC_ON]) ##1 !wr_en ##1 !wr_en ##1
        (rd_en && addr == ADDR_COUNT_LOW) |=> rdata == $past(rdata, 3))
        else $error("count moved while off");

    cover property (overflow_irq);
    cover property (gate_event_irq);
    cover property (wake_up);
endmodule : gtm_chk

//--- gtm_tb.sv
// Self-checking bench for the gated timer
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
        end \
    end
module testbench
    import gtm_pkg::*;
;
    logic       clock, rst_n, wr_en, rd_en, gate_pin, comp, sleep_mode;
    logic       t8_run, clk_run, clk_pin, lf_osc, ovf_irq, gate_irq, wake;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, t8_count, v;
    logic [15:0] c;
    int         fails, total_checks;

    gtm_far gtm_far_inst (.clock(clock), .rst_n(rst_n), .t8_run(t8_run),
        .clk_run(clk_run), .t8_count(t8_count), .clk_pin(clk_pin), .lf_osc(lf_osc));
    gtm_timer gtm_timer_inst (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .external_gate_pin(gate_pin),
        .external_clock_pin(clk_pin), .low_freq_internal_osc(lf_osc),
        .comparator1_output(comp), .timer8_count(t8_count), .sleep_mode(sleep_mode),
        .overflow_irq(ovf_irq), .gate_event_irq(gate_irq), .wake_up(wake));

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        // Read data stand in the cycle after the strobe; take them at its end
        @(posedge clock);
        d = rdata;
    endtask : rd

    // Start and stop share one latency, so only edge phase blurs the count
    function automatic logic near(input logic [15:0] x, input int e);
        return (int'(x) >= e - 2) && (int'(x) <= e + 2);
    endfunction : near

    task automatic run_count(input logic [7:0] tc, input int n, output logic [15:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_TIMER_CTRL, tc);
        repeat (n) @(posedge clock);
        wr(ADDR_TIMER_CTRL, 8'h00);
        rd(ADDR_COUNT_LOW, lo);
        rd(ADDR_COUNT_HIGH, hi);
        r = {hi, lo};
    endtask : run_count

    task automatic t_regs;
        wr(ADDR_TIMER_CTRL, 8'hfe);
        rd(ADDR_TIMER_CTRL, v);
        `CHK(v, 8'hf4)
        wr(ADDR_GATE_CTRL, 8'hf3);
        rd(ADDR_GATE_CTRL, v);
        `CHK(v & 8'hf3, 8'hf3)
        rd(3'h7, v);
        `CHK(v, 8'h00)
        wr(ADDR_GATE_CTRL, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h12);
        rd(ADDR_COUNT_LOW, v);
        `CHK(v, 8'h12)
        wr(ADDR_COUNT_HIGH, 8'h34);
        rd(ADDR_COUNT_HIGH, v);
        `CHK(v, 8'h34)
        rd(ADDR_COUNT_LOW, v);
        rd(ADDR_COUNT_LOW, v);
        `CHK(v, 8'h12)
        $display("registers done");
    endtask : t_regs

    task automatic t_clk;
        logic [7:0] tcs [7] = '{8'h01, 8'h41, 8'h51, 8'h61, 8'h71, 8'h81, 8'hc1};
        int dv [7] = '{4, 1, 2, 4, 8, 4, 8};
        clk_run <= 1'b1;
        foreach (tcs[i])
        begin
            run_count(tcs[i], 64, c);
            `CHK(near(c, 66 / dv[i]), 1'b1)
        end
        clk_run <= 1'b0;
        $display("clock sources done");
    endtask : t_clk

    task automatic t_gate;
        wr(ADDR_INT_CTRL, 8'h38);
        wr(ADDR_GATE_CTRL, 8'hc0);
        run_count(8'h41, 20, c);
        `CHK(c, 16'h0000)
        gate_pin <= 1'b1;
        run_count(8'h41, 20, c);
        `CHK(near(c, 22), 1'b1)
        wr(ADDR_GATE_CTRL, 8'h80);
        run_count(8'h41, 20, c);
        `CHK(c, 16'h0000)
        wr(ADDR_GATE_CTRL, 8'h40);
        rd(ADDR_GATE_CTRL, v);
        `CHK(v[GC_VAL], 1'b1)
        // Polarity changes above already set the flag; clear it first
        wr(ADDR_INT_CTRL, 8'h38);
        rd(ADDR_INT_CTRL, v);
        `CHK(v[IC_GATE_FLAG], 1'b0)
        `CHK(gate_irq, 1'b0)
        gate_pin <= 1'b0;
        repeat (8) @(posedge clock);
        rd(ADDR_INT_CTRL, v);
        `CHK(v[IC_GATE_FLAG], 1'b1)
        `CHK(gate_irq, 1'b1)
        wr(ADDR_INT_CTRL, 8'h00);
        $display("gate done");
    endtask : t_gate

    task automatic t_single(input logic [7:0] gc, input int e);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_TIMER_CTRL, 8'h41);
        wr(ADDR_GATE_CTRL, gc);
        wr(ADDR_GATE_CTRL, gc | 8'h08);
        repeat (2)
        begin
            repeat (10) @(posedge clock);
            gate_pin <= 1'b1;
            repeat (10) @(posedge clock);
            gate_pin <= 1'b0;
        end
        repeat (10) @(posedge clock);
        wr(ADDR_TIMER_CTRL, 8'h00);
        rd(ADDR_GATE_CTRL, v);
        `CHK(v[GC_GO], 1'b0)
        rd(ADDR_COUNT_LOW, v);
        `CHK(near({8'h00, v}, e), 1'b1)
        wr(ADDR_GATE_CTRL, 8'h00);
        $display("single pulse done");
    endtask : t_single

    task automatic t_ovf;
        wr(ADDR_INT_CTRL, 8'h32);
        wr(ADDR_COUNT_LOW, 8'hfa);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_TIMER_CTRL, 8'h41);
        repeat (20) @(posedge clock);
        `CHK(ovf_irq, 1'b1)
        wr(ADDR_INT_CTRL, 8'h13);
        repeat (2) @(posedge clock);
        `CHK(ovf_irq, 1'b0)
        `CHK(wake, 1'b1)
        wr(ADDR_TIMER_CTRL, 8'h00);
        repeat (2) @(posedge clock);
        `CHK(wake, 1'b0)
        wr(ADDR_INT_CTRL, 8'h12);
        wr(ADDR_COUNT_LOW, 8'hfd);
        wr(ADDR_COUNT_HIGH, 8'hff);
        sleep_mode <= 1'b1;
        clk_run    <= 1'b1;
        wr(ADDR_TIMER_CTRL, 8'h81);
        repeat (40) @(posedge clock);
        `CHK(wake, 1'b0)
        wr(ADDR_TIMER_CTRL, 8'h85);
        repeat (40) @(posedge clock);
        `CHK(wake, 1'b1)
        sleep_mode <= 1'b0;
        clk_run    <= 1'b0;
        wr(ADDR_TIMER_CTRL, 8'h00);
        wr(ADDR_INT_CTRL, 8'h00);
        $display("overflow done");
    endtask : t_ovf

    task automatic t_src;
        wr(ADDR_GATE_CTRL, 8'h41);
        // Source switch drops the gate level; let that flag land, then clear it
        repeat (4) @(posedge clock);
        wr(ADDR_INT_CTRL, 8'h00);
        rd(ADDR_INT_CTRL, v);
        `CHK(v[IC_GATE_FLAG], 1'b0)
        t8_run <= 1'b1;
        repeat (300) @(posedge clock);
        rd(ADDR_INT_CTRL, v);
        `CHK(v[IC_GATE_FLAG], 1'b1)
        t8_run <= 1'b0;
        wr(ADDR_INT_CTRL, 8'h00);
        wr(ADDR_GATE_CTRL, 8'h42);
        comp <= 1'b1;
        repeat (8) @(posedge clock);
        comp <= 1'b0;
        repeat (8) @(posedge clock);
        rd(ADDR_INT_CTRL, v);
        `CHK(v[IC_GATE_FLAG], 1'b1)
        $display("gate sources done");
    endtask : t_src

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        end_of_test();
    end

    initial
    begin
        {rst_n, wr_en, rd_en, gate_pin, comp, sleep_mode, t8_run, clk_run} = '0;
        addr  = 3'h0;
        wdata = 8'h00;
        fails = 0;
        total_checks = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_clk();
        t_gate();
        t_single(8'hd0, 10);
        t_single(8'hf0, 20);
        t_ovf();
        t_src();
        end_of_test();
    end
endmodule : testbench

bind gtm_timer gtm_chk gtm_chk_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .external_gate_pin(external_gate_pin), .external_clock_pin(external_clock_pin),
    .low_freq_internal_osc(low_freq_internal_osc), .comparator1_output(comparator1_output),
    .timer8_count(timer8_count), .sleep_mode(sleep_mode), .overflow_irq(overflow_irq),
    .gate_event_irq(gate_event_irq), .wake_up(wake_up));
